// *** core/ttc_defines.vh ***
// Constants of the T1/E1 transceiver control core
// Overview of operation
// - Host mode: alert pin pulled low once signal-loss or driver-watch rises, until the host clears the latch.
// - Host mode: serial input sampled on every rising serial clock edge.
// - Serial output valid on rising edge if edge-select high, else falling.
// - Serial output floats while the port is written or select is high.
// - Hardware mode: remote-loop pin enables remote loopback; both loops mean reset.
// - Hardware mode: local-loop pin high enables local loopback.
// - Edge-select high in host mode: receive data valid on falling clock edge, else rising.
// - Hardware mode: all-marks pin sends continuous marks at master rate.
// - Transmit data arrives serially on pos/neg inputs, captured by transmit clock.
// - Without transmit clock the transmitter stays off, except in remote loopback.
// - Host mode: pulse-shape value comes in the serial stream, not pins.
// - Transmit data buffered in 32x2 store, written by tx clock, read dejittered.
// - Fill within two of overflow or underflow shifts read clock one eighth bit.
// - Store held around half full, giving sixteen bits of average latency.
// - Driver-watch flag rises after 63 consecutive zeros on monitored line.
// - Driver-watch flag clears on a seen one or on a reset command.
// - Dejittered read clock derived from reference at four times bit rate.
// - Mode pin high selects host mode, low selects hardware pin control.
// - Signal-loss flag rises after 175 consecutive spaces, clears on a mark.
// - Pulse-shape value zero means E1 operation, any other value T1.
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH

// Wishbone byte addresses
`define TTC_WB_CTRL      4'h0
`define TTC_WB_STAT      4'h4
`define TTC_WB_CTRL_RST  0

// Serial port register addresses and fields
`define TTC_SP_CTRL      4'h0
`define TTC_SP_STAT      4'h1
`define TTC_SP_RD_BIT    0
`define TTC_SP_CMD_BITS  5'h08
`define TTC_SP_LAST_BIT  5'h0F
`define TTC_CTL_REMOTE   3
`define TTC_CTL_LOCAL    4
`define TTC_CTL_MARKS    5
`define TTC_CTL_RST      6
`define TTC_STA_SIGLOSS  0
`define TTC_STA_DRVWATCH 1
`define TTC_SP_CTRL_RST  8'h00

// Line monitor counts
`define TTC_SIGLOSS_CNT  8'hAF
`define TTC_DRVWATCH_CNT 6'h3F
`define TTC_E1_SHAPE     3'h0

// Elastic store
`define TTC_STORE_DEPTH  32
`define TTC_STORE_AW     5
`define TTC_FILL_MARGIN  6'h02
`define TTC_FILL_HALF    6'h10
`define TTC_REF_PER_BIT  4

// Transmit clock absence timeout
`define TTC_CLK_MHZ      25
`define TTC_TXCLK_LOSS_NS 2000

`endif

// *** core/ttc_sync.v ***
// Three-stage synchroniser bank with agreement filter
`timescale 1ns/1ps
module ttc_sync #(
	parameter WIDTH = 1,
	parameter INIT  = 0
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;
	integer i;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= INIT[WIDTH-1:0];
			s2_q <= INIT[WIDTH-1:0];
			s3_q <= INIT[WIDTH-1:0];
			dout <= INIT[WIDTH-1:0];
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change accepted only once stages two and three agree
			for (i = 0; i < WIDTH; i = i + 1) begin
				if (s2_q[i] == s3_q[i])
					dout[i] <= s3_q[i];
			end
		end
	end
endmodule

// *** core/ttc_store_mem.v ***
// Elastic store memory, registered read data
`timescale 1ns/1ps
module ttc_store_mem #(
	parameter DW    = 2,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire          clk,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire          rd_en,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:DEPTH-1];

	always @(posedge clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		if (rd_en)
			rd_data <= mem[rd_addr];
	end
endmodule

// *** core/ttc_core.v ***
// T1/E1 transceiver digital control core
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ttc_defines.vh"
module ttc_core #(
	parameter REF_DIV      = 2,
	parameter STORE_DEPTH  = `TTC_STORE_DEPTH,
	parameter STORE_AW     = `TTC_STORE_AW
) (
	input  wire        CLOCK,
	input  wire        RST_N,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [3:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	input  wire        MODE,
	input  wire        EDGE_SELECT,
	input  wire        CS_N,
	input  wire        SCLK,
	input  wire        SER_IN,
	output reg         SER_OUT,
	output reg         SER_OUT_OE,
	output reg         ALERT_N_O,
	output reg         ALERT_N_OE,
	input  wire        PULSE_SHAPE_SEL0,
	input  wire        PULSE_SHAPE_SEL1,
	input  wire        PULSE_SHAPE_SEL2,
	input  wire        REMOTE_LOOP,
	input  wire        LOCAL_LOOP,
	input  wire        SEND_ALL_MARKS,
	input  wire        TX_CLK,
	input  wire        TX_POS_DATA,
	input  wire        TX_NEG_DATA,
	input  wire        RX_CLK,
	input  wire        RX_POS_IN,
	input  wire        RX_NEG_IN,
	input  wire        MON_LINE,
	output reg         RX_POS_DATA,
	output reg         RX_NEG_DATA,
	output reg         LINE_OUT_A,
	output reg         LINE_OUT_B,
	output reg  [2:0]  PULSE_SHAPE,
	output reg         E1_MODE,
	output reg         TX_POWER_ON,
	output reg         SIGNAL_LOSS,
	output reg         DRIVER_WATCH
);
	localparam [7:0] BIT_CYC = 4 * REF_DIV;
	localparam [7:0] HALF_ADJ = (REF_DIV / 2 < 1) ? 1 : REF_DIV / 2;
	localparam integer LOSS_CYC =
		(`TTC_TXCLK_LOSS_NS * `TTC_CLK_MHZ + 999) / 1000;
	localparam [STORE_AW:0] FILL_FULL = STORE_DEPTH;
	localparam [STORE_AW:0] FILL_HI = FILL_FULL - `TTC_FILL_MARGIN;

	// Synchronised pins, CS_N idles high
	wire [17:0] pin_s;
	ttc_sync #(.WIDTH(18), .INIT(18'h08000)) u_sync (
		.clk  (CLOCK),
		.rst_n(RST_N),
		.din  ({MODE, EDGE_SELECT, CS_N, SCLK, SER_IN, TX_CLK,
			TX_POS_DATA, TX_NEG_DATA, RX_CLK, RX_POS_IN,
			RX_NEG_IN, MON_LINE, PULSE_SHAPE_SEL2,
			PULSE_SHAPE_SEL1, PULSE_SHAPE_SEL0, REMOTE_LOOP,
			LOCAL_LOOP, SEND_ALL_MARKS}),
		.dout (pin_s)
	);
	wire host_mode = pin_s[17];
	wire edge_sel  = pin_s[16];
	wire cs_n_s    = pin_s[15];
	wire sclk_s    = pin_s[14];
	wire ser_in_s  = pin_s[13];
	wire txclk_s   = pin_s[12];
	wire txpos_s   = pin_s[11];
	wire txneg_s   = pin_s[10];
	wire rxclk_s   = pin_s[9];
	wire rxpos_s   = pin_s[8];
	wire rxneg_s   = pin_s[7];
	wire mon_s     = pin_s[6];
	wire [2:0] shape_pins = pin_s[5:3];
	wire remote_loop_pin = pin_s[2];
	wire local_loop_pin = pin_s[1];
	wire marks_pin = pin_s[0];

	reg sclk_p_q;
	reg txclk_p_q;
	reg rxclk_p_q;
	wire sclk_rise  = sclk_s & ~sclk_p_q;
	wire sclk_fall  = ~sclk_s & sclk_p_q;
	wire txclk_rise = txclk_s & ~txclk_p_q;
	wire rxclk_rise = rxclk_s & ~rxclk_p_q;
	wire rxclk_fall = ~rxclk_s & rxclk_p_q;

	// Serial port state
	reg [4:0] sp_cnt_q;
	reg [7:0] sp_cmd_q;
	reg [7:0] sp_dat_q;
	reg [7:0] sp_sh_q;
	reg       sp_rd_q;
	reg       sp_armed_q;
	reg [7:0] sp_ctrl_q;
	reg       sl_lat_q;
	reg       dw_lat_q;
	reg       sl_prev_q;
	reg       dw_prev_q;
	reg       wb_rst_q;

	wire port_on  = host_mode & ~cs_n_s;
	wire sp_take  = port_on & sclk_rise;
	wire sp_last  = sp_take & (sp_cnt_q == `TTC_SP_LAST_BIT);
	wire sp_wr    = sp_last & ~sp_cmd_q[`TTC_SP_RD_BIT];
	wire [3:0] sp_addr = sp_cmd_q[4:1];
	wire [7:0] sp_wdata = {ser_in_s, sp_dat_q[7:1]};

	// Effective controls from pins or serial register
	wire [2:0] shape_d = host_mode ? sp_ctrl_q[2:0] : shape_pins;
	wire remote_loop = host_mode ? sp_ctrl_q[`TTC_CTL_REMOTE] : remote_loop_pin;
	wire local_loop = host_mode ? sp_ctrl_q[`TTC_CTL_LOCAL]  : local_loop_pin;
	wire marks = host_mode ? sp_ctrl_q[`TTC_CTL_MARKS]  : marks_pin;
	wire pin_rst = ~host_mode & remote_loop_pin & local_loop_pin;
	wire sp_rst  = sp_wr & (sp_addr == `TTC_SP_CTRL) &
		sp_wdata[`TTC_CTL_RST];
	wire rst_cmd = pin_rst | sp_rst | wb_rst_q;
	wire remote_loop_on = remote_loop & ~pin_rst;
	wire local_loop_on = local_loop & ~pin_rst;

	function [7:0] stat_byte;
		input sl;
		input dw;
		begin
			stat_byte = 8'h00;
			stat_byte[`TTC_STA_SIGLOSS]  = sl;
			stat_byte[`TTC_STA_DRVWATCH] = dw;
		end
	endfunction

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_p_q   <= 1'b0;
			txclk_p_q  <= 1'b0;
			rxclk_p_q  <= 1'b0;
			sp_cnt_q   <= 5'h00;
			sp_cmd_q   <= 8'h00;
			sp_dat_q   <= 8'h00;
			sp_sh_q    <= 8'h00;
			sp_rd_q    <= 1'b0;
			sp_armed_q <= 1'b0;
			sp_ctrl_q  <= `TTC_SP_CTRL_RST;
			SER_OUT    <= 1'b0;
			SER_OUT_OE <= 1'b0;
		end else begin
			sclk_p_q  <= sclk_s;
			txclk_p_q <= txclk_s;
			rxclk_p_q <= rxclk_s;
			if (!port_on) begin
				// Each access starts at select falling
				sp_cnt_q   <= 5'h00;
				sp_rd_q    <= 1'b0;
				sp_armed_q <= 1'b0;
				SER_OUT_OE <= 1'b0;
			end else begin
				if (sp_take) begin
					if (sp_cnt_q < `TTC_SP_CMD_BITS)
						sp_cmd_q <= {ser_in_s, sp_cmd_q[7:1]};
					else
						sp_dat_q <= {ser_in_s, sp_dat_q[7:1]};
					if (sp_cnt_q != `TTC_SP_LAST_BIT)
						sp_cnt_q <= sp_cnt_q + 5'h01;
				end
				// Read data loaded after last command bit
				if (sp_take && sp_cnt_q == `TTC_SP_CMD_BITS - 5'h01 &&
					sp_cmd_q[1] == 1'b1) begin
					sp_rd_q    <= 1'b1;
					sp_armed_q <= 1'b0;
					sp_sh_q    <= (sp_cmd_q[5:2] == `TTC_SP_STAT) ?
						stat_byte(sl_lat_q, dw_lat_q) :
						(sp_cmd_q[5:2] == `TTC_SP_CTRL) ?
						sp_ctrl_q : 8'h00;
				end
				if (sp_rd_q) begin
					SER_OUT_OE <= 1'b1;
					SER_OUT    <= sp_sh_q[0];
					// Shift on the edge opposite the valid edge
					if (edge_sel ? (sclk_fall && sp_armed_q)
						: (sclk_rise && sp_armed_q))
						sp_sh_q <= {1'b0, sp_sh_q[7:1]};
					if (edge_sel ? sclk_rise : sclk_fall)
						sp_armed_q <= 1'b1;
				end
				if (sp_wr && sp_addr == `TTC_SP_CTRL)
					sp_ctrl_q <= sp_wdata & ~(8'h01 << `TTC_CTL_RST);
			end
		end
	end

	// Store state, declared ahead of the status read that shows it
	reg [STORE_AW:0] wr_ptr_q;
	reg [STORE_AW:0] rd_ptr_q;
	reg              run_q;
	reg [7:0]        ph_q;
	reg [7:0]        ref_q;
	reg              am_q;
	reg [7:0]        txw_q;
	reg [7:0]        sl_cnt_q;
	reg [5:0]        dw_cnt_q;
	wire [1:0]       mem_q;
	wire [STORE_AW:0] fill = wr_ptr_q - rd_ptr_q;

	// Wishbone slave, one wait state
	wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			wb_rst_q <= 1'b0;
		end else begin
			WB_ACK_O <= wb_req;
			wb_rst_q <= wb_req & WB_WE_I & WB_SEL_I[0] &
				(WB_ADR_I == `TTC_WB_CTRL) &
				WB_DAT_I[`TTC_WB_CTRL_RST];
			if (wb_req && !WB_WE_I)
				case (WB_ADR_I)
				`TTC_WB_STAT:
					WB_DAT_O <= {16'h0000, 2'b00, fill, 2'b00,
						run_q, TX_POWER_ON, E1_MODE, host_mode,
						DRIVER_WATCH, SIGNAL_LOSS};
				default:
					WB_DAT_O <= 32'h00000000;
				endcase
			else
				WB_DAT_O <= 32'h00000000;
		end
	end

	// Alert latches, hardware set wins over host clear
	wire sl_set = SIGNAL_LOSS & ~sl_prev_q;
	wire dw_set = DRIVER_WATCH & ~dw_prev_q;
	wire st_wr  = sp_wr & (sp_addr == `TTC_SP_STAT);
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sl_prev_q  <= 1'b0;
			dw_prev_q  <= 1'b0;
			sl_lat_q   <= 1'b0;
			dw_lat_q   <= 1'b0;
			ALERT_N_O  <= 1'b0;
			ALERT_N_OE <= 1'b0;
		end else begin
			sl_prev_q <= SIGNAL_LOSS;
			dw_prev_q <= DRIVER_WATCH;
			if (sl_set)
				sl_lat_q <= 1'b1;
			else if (st_wr && !sp_wdata[`TTC_STA_SIGLOSS])
				sl_lat_q <= 1'b0;
			if (dw_set)
				dw_lat_q <= 1'b1;
			else if (rst_cmd ||
				(st_wr && !sp_wdata[`TTC_STA_DRVWATCH]))
				dw_lat_q <= 1'b0;
			ALERT_N_O  <= 1'b0;
			ALERT_N_OE <= host_mode & (sl_lat_q | dw_lat_q);
		end
	end

	// Elastic store
	wire bit_tick = (ph_q == 8'h00);
	wire st_wr_en = txclk_rise & (fill != FILL_FULL);
	wire st_rd_en = bit_tick & run_q & (fill != {(STORE_AW+1){1'b0}});

	ttc_store_mem #(.DW(2), .DEPTH(STORE_DEPTH), .AW(STORE_AW)) u_mem (
		.clk    (CLOCK),
		.wr_en  (st_wr_en),
		.wr_addr(wr_ptr_q[STORE_AW-1:0]),
		.wr_data({txpos_s, txneg_s}),
		.rd_en  (st_rd_en),
		.rd_addr(rd_ptr_q[STORE_AW-1:0]),
		.rd_data(mem_q)
	);

	// Bit period length with one-eighth bit slip
	function [7:0] next_len;
		input [STORE_AW:0] f;
		begin
			if (f <= `TTC_FILL_MARGIN)
				next_len = BIT_CYC - 8'h01 + HALF_ADJ;
			else if (f >= FILL_HI)
				next_len = BIT_CYC - 8'h01 - HALF_ADJ;
			else
				next_len = BIT_CYC - 8'h01;
		end
	endfunction

	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			wr_ptr_q    <= {(STORE_AW+1){1'b0}};
			rd_ptr_q    <= {(STORE_AW+1){1'b0}};
			run_q       <= 1'b0;
			ph_q        <= 8'h00;
			ref_q       <= 8'h00;
			am_q        <= 1'b0;
			txw_q       <= 8'h00;
			TX_POWER_ON <= 1'b0;
			LINE_OUT_A  <= 1'b0;
			LINE_OUT_B  <= 1'b0;
			PULSE_SHAPE <= 3'h0;
			E1_MODE     <= 1'b1;
		end else begin
			PULSE_SHAPE <= shape_d;
			E1_MODE     <= (shape_d == `TTC_E1_SHAPE);
			// Reference divider, four ticks per nominal bit
			ref_q <= (ref_q == 8'h00) ? REF_DIV[7:0] - 8'h01 :
				ref_q - 8'h01;
			ph_q <= bit_tick ? next_len(fill) : ph_q - 8'h01;
			if (txclk_rise)
				txw_q <= LOSS_CYC[7:0];
			else if (txw_q != 8'h00)
				txw_q <= txw_q - 8'h01;
			TX_POWER_ON <= (txw_q != 8'h00) | remote_loop_on;
			if (rst_cmd) begin
				wr_ptr_q <= {(STORE_AW+1){1'b0}};
				rd_ptr_q <= {(STORE_AW+1){1'b0}};
				run_q    <= 1'b0;
			end else begin
				if (st_wr_en)
					wr_ptr_q <= wr_ptr_q + 1'b1;
				if (st_rd_en)
					rd_ptr_q <= rd_ptr_q + 1'b1;
				// Start reading only at half fill
				if (fill >= `TTC_FILL_HALF)
					run_q <= 1'b1;
				else if (fill == {(STORE_AW+1){1'b0}})
					run_q <= 1'b0;
			end
			if (bit_tick) begin
				am_q <= ~am_q;
				if (!TX_POWER_ON) begin
					LINE_OUT_A <= 1'b0;
					LINE_OUT_B <= 1'b0;
				end else if (remote_loop_on) begin
					LINE_OUT_A <= rxpos_s;
					LINE_OUT_B <= rxneg_s;
				end else if (marks & ~host_mode) begin
					LINE_OUT_A <= am_q;
					LINE_OUT_B <= ~am_q;
				end else begin
					LINE_OUT_A <= run_q & mem_q[1];
					LINE_OUT_B <= run_q & mem_q[0];
				end
			end
		end
	end

	// Receive path, signal loss and driver watch
	wire rx_upd = (host_mode && edge_sel) ? rxclk_rise : rxclk_fall;
	always @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			sl_cnt_q     <= 8'h00;
			dw_cnt_q     <= 6'h00;
			SIGNAL_LOSS  <= 1'b0;
			DRIVER_WATCH <= 1'b0;
			RX_POS_DATA  <= 1'b0;
			RX_NEG_DATA  <= 1'b0;
		end else begin
			if (rx_upd) begin
				RX_POS_DATA <= local_loop_on ? LINE_OUT_A : rxpos_s;
				RX_NEG_DATA <= local_loop_on ? LINE_OUT_B : rxneg_s;
			end
			if (rst_cmd) begin
				sl_cnt_q    <= 8'h00;
				SIGNAL_LOSS <= 1'b0;
			end else if (rxclk_rise) begin
				if (rxpos_s | rxneg_s) begin
					sl_cnt_q    <= 8'h00;
					SIGNAL_LOSS <= 1'b0;
				end else if (sl_cnt_q != `TTC_SIGLOSS_CNT) begin
					sl_cnt_q <= sl_cnt_q + 8'h01;
					if (sl_cnt_q == `TTC_SIGLOSS_CNT - 8'h01)
						SIGNAL_LOSS <= 1'b1;
				end
			end
			if (rst_cmd) begin
				dw_cnt_q     <= 6'h00;
				DRIVER_WATCH <= 1'b0;
			end else if (bit_tick) begin
				if (mon_s) begin
					dw_cnt_q     <= 6'h00;
					DRIVER_WATCH <= 1'b0;
				end else if (dw_cnt_q != `TTC_DRVWATCH_CNT) begin
					dw_cnt_q <= dw_cnt_q + 6'h01;
					if (dw_cnt_q == `TTC_DRVWATCH_CNT - 6'h01)
						DRIVER_WATCH <= 1'b1;
				end
			end
		end
	end
endmodule

// *** tb/ttc_core_checker.sv ***
// Port-level assertions for the transceiver control core
`timescale 1ns/1ps
module ttc_core_checker #(
	parameter REF_DIV = 2
) (
	input logic       CLOCK,
	input logic       RST_N,
	input logic       WB_CYC_I,
	input logic       WB_STB_I,
	input logic       WB_ACK_O,
	input logic       MODE,
	input logic       CS_N,
	input logic       SER_OUT_OE,
	input logic       ALERT_N_O,
	input logic       ALERT_N_OE,
	input logic       REMOTE_LOOP,
	input logic       LOCAL_LOOP,
	input logic       SEND_ALL_MARKS,
	input logic       TX_CLK,
	input logic       MON_LINE,
	input logic       LINE_OUT_A,
	input logic       LINE_OUT_B,
	input logic [2:0] PULSE_SHAPE,
	input logic       E1_MODE,
	input logic       TX_POWER_ON,
	input logic       SIGNAL_LOSS,
	input logic       DRIVER_WATCH
);
	// One bit tick plus synchroniser slack
	localparam int TK = 4 * REF_DIV + 8;
	logic [7:0] idle_q;
	logic [9:0] zero_q;
	logic       tx_q;
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_N);
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			idle_q <= 8'h00;
			zero_q <= 10'h000;
			tx_q <= 1'b0;
		end else begin
			tx_q <= TX_CLK;
			zero_q <= MON_LINE ? 10'h000 : zero_q + {9'h000, zero_q != 10'h3FF};
			if (TX_CLK != tx_q || REMOTE_LOOP) idle_q <= 8'h00;
			else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
		end
	end
	AST_WB_ACK: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=>
		WB_ACK_O ##1 !WB_ACK_O) else $error("bus request not acked");
	AST_ALERT_SET: assert property (
		MODE && $rose(SIGNAL_LOSS || DRIVER_WATCH) |-> ##[1:3] ALERT_N_OE)
		else $error("alert not pulled low");
	AST_ALERT_LOW: assert property (!ALERT_N_O)
		else $error("alert data not low");
	AST_SER_IDLE: assert property (CS_N [*8] |-> !SER_OUT_OE)
		else $error("serial out driven while deselected");
	AST_HW_QUIET: assert property (!MODE [*8] |-> !SER_OUT_OE)
		else $error("serial out driven in pin mode");
	AST_E1_SHAPE: assert property (
		$stable(PULSE_SHAPE) |-> E1_MODE == (PULSE_SHAPE == 3'h0))
		else $error("line standard flag wrong");
	AST_LOOP_RESET: assert property (
		(!MODE && REMOTE_LOOP && LOCAL_LOOP) [*8] |-> !SIGNAL_LOSS && !DRIVER_WATCH)
		else $error("loop pins did not reset");
	AST_DW_CLEAR: assert property (
		(DRIVER_WATCH && MON_LINE) [*8] |-> ##[0:TK] !DRIVER_WATCH)
		else $error("driver watch stuck");
	AST_DW_EARLY: assert property (
		$rose(DRIVER_WATCH) |-> zero_q >= 10'h1AE)
		else $error("driver watch raised too soon");
	AST_TX_IDLE: assert property (idle_q >= 8'h46 |-> !TX_POWER_ON)
		else $error("transmitter on without clock");
	AST_MARKS: assert property (
		(!MODE && SEND_ALL_MARKS && !REMOTE_LOOP && !LOCAL_LOOP && TX_POWER_ON)
		[*8] |-> ##[0:TK] LINE_OUT_A != LINE_OUT_B)
		else $error("marks not sent");
endmodule
bind ttc_core ttc_core_checker #(.REF_DIV(REF_DIV)) u_ttc_core_checker (
	.CLOCK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .MODE, .CS_N,
	.SER_OUT_OE, .ALERT_N_O, .ALERT_N_OE, .REMOTE_LOOP, .LOCAL_LOOP,
	.SEND_ALL_MARKS, .TX_CLK, .MON_LINE, .LINE_OUT_A, .LINE_OUT_B,
	.PULSE_SHAPE, .E1_MODE, .TX_POWER_ON, .SIGNAL_LOSS, .DRIVER_WATCH
);

// *** tb/ttc_host_model.sv ***
// Behavioural host on the serial control port
`timescale 1ns/1ps
module ttc_host_model (
	input  logic CLOCK,
	input  logic SER_OUT,
	input  logic SER_OUT_OE,
	output logic CS_N,
	output logic SCLK,
	output logic SER_IN
);
	initial begin
		CS_N = 1'b1;
		SCLK = 1'b0;
		SER_IN = 1'b0;
	end
	// Half period of 8 cycles outlasts the core's input synchronisers
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
		input logic es, output logic [7:0] rd, output logic oe_bad);
		int i;
		rd = 8'h00;
		oe_bad = 1'b0;
		CS_N <= 1'b0;
		for (i = 0; i < 16; i++) begin
			// Read data phase input toggles so it cannot be mistaken
			SER_IN <= i < 8 ? cmd[i] : (cmd[0] ? ~SER_IN : dat[i-8]);
			repeat (8) @(posedge CLOCK);
			SCLK <= 1'b1;
			if (es && i > 7) rd[i-8] = SER_OUT;
			if (i > 7) oe_bad |= SER_OUT_OE !== cmd[0];
			repeat (8) @(posedge CLOCK);
			SCLK <= 1'b0;
			if (!es && i > 6 && i < 15) rd[i-7] = SER_OUT;
		end
		repeat (8) @(posedge CLOCK);
		CS_N <= 1'b1;
		SER_IN <= ~SER_IN;
		repeat (12) @(posedge CLOCK);
	endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the transceiver control core
`timescale 1ns/1ps
module testbench;
	logic        CLOCK = 1'b0, RST_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0;
	logic        WB_WE_I = 1'b0, MODE = 1'b1, EDGE_SELECT = 1'b0, TX_CLK = 1'b0;
	logic        PULSE_SHAPE_SEL0 = 1'b0, PULSE_SHAPE_SEL1 = 1'b0;
	logic        PULSE_SHAPE_SEL2 = 1'b0, REMOTE_LOOP = 1'b0, LOCAL_LOOP = 1'b0;
	logic        SEND_ALL_MARKS = 1'b0, TX_POS_DATA = 1'b0, TX_NEG_DATA = 1'b0;
	logic        RX_CLK = 1'b0, RX_POS_IN = 1'b0, RX_NEG_IN = 1'b0, MON_LINE = 1'b1;
	logic [3:0]  WB_ADR_I = 4'h0, WB_SEL_I = 4'hF;
	logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q, seed = 32'h000173C2;
	logic        WB_ACK_O, CS_N, SCLK, SER_IN, SER_OUT, SER_OUT_OE, ALERT_N_O;
	logic        ALERT_N_OE, RX_POS_DATA, RX_NEG_DATA, LINE_OUT_A, LINE_OUT_B;
	logic        E1_MODE, TX_POWER_ON, SIGNAL_LOSS, DRIVER_WATCH, bad, tx_run = 1'b0;
	logic [2:0]  PULSE_SHAPE, s;
	logic [7:0]  rd;
	int          errors = 0, checks_done = 0;
	ttc_core #(.REF_DIV(2)) u_ttc_core (.CLOCK, .RST_N, .WB_CYC_I, .WB_STB_I,
		.WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .MODE,
		.EDGE_SELECT, .CS_N, .SCLK, .SER_IN, .SER_OUT, .SER_OUT_OE, .ALERT_N_O,
		.ALERT_N_OE, .PULSE_SHAPE_SEL0, .PULSE_SHAPE_SEL1, .PULSE_SHAPE_SEL2,
		.REMOTE_LOOP, .LOCAL_LOOP, .SEND_ALL_MARKS, .TX_CLK, .TX_POS_DATA,
		.TX_NEG_DATA, .RX_CLK, .RX_POS_IN, .RX_NEG_IN, .MON_LINE, .RX_POS_DATA,
		.RX_NEG_DATA, .LINE_OUT_A, .LINE_OUT_B, .PULSE_SHAPE, .E1_MODE,
		.TX_POWER_ON, .SIGNAL_LOSS, .DRIVER_WATCH);
	ttc_host_model u_host (.CLOCK, .SER_OUT, .SER_OUT_OE, .CS_N, .SCLK, .SER_IN);
	always #20 CLOCK = ~CLOCK;
	// Odd offset keeps link edges apart from system clock edges
	initial begin
		#13;
		forever #160 TX_CLK = tx_run ? ~TX_CLK : 1'b0;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [31:0] exp_stat(input logic sl, dw, hm, e1, pw);
		return {27'h0, pw, e1, hm, dw, sl};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= we;
		WB_ADR_I <= a;
		WB_DAT_I <= d;
		do begin
			@(posedge CLOCK);
			n++;
		end while (WB_ACK_O !== 1'b1 && n < 20);
		if (n == 20) errors++;
		q = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		@(posedge CLOCK);
	endtask
	task ser(input logic [7:0] cmd, input logic [7:0] dat);
		q = rnd();
		EDGE_SELECT <= q[0];
		u_host.xfer(cmd, dat, q[0], rd, bad);
		chk(bad, 0);
	endtask
	task rxbits(input int n, input logic p);
		repeat (n) begin
			RX_POS_IN <= p;
			repeat (4) @(posedge CLOCK);
			RX_CLK <= 1'b1;
			repeat (4) @(posedge CLOCK);
			RX_CLK <= 1'b0;
		end
		repeat (8) @(posedge CLOCK);
	endtask
	task summarize();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge CLOCK);
		errors++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge CLOCK);
		RST_N <= 1'b1;
		repeat (6) @(posedge CLOCK);
		wb(0, 4'h4, 32'h0);
		chk(q, exp_stat(0, 0, 1, 1, 0));
		wb(0, 4'h8, 32'h0);
		chk(q, 32'h0);
		for (int k = 0; k < 8; k++) begin
			s = k[2:0];
			q = rnd();
			ser({q[7:5], 4'h0, 1'b0}, {5'h00, s});
			chk(PULSE_SHAPE, s);
			chk(E1_MODE, s == 3'h0);
			ser({q[4:2], 4'h0, 1'b1}, 8'h00);
			chk(rd, s);
		end
		MODE <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			s = rnd();
			{PULSE_SHAPE_SEL2, PULSE_SHAPE_SEL1, PULSE_SHAPE_SEL0} <= s;
			repeat (8) @(posedge CLOCK);
			ser(8'h00, {5'h00, ~s});
			chk(PULSE_SHAPE, s);
		end
		MODE <= 1'b1;
		TX_POS_DATA <= 1'b1;
		tx_run <= 1'b1;
		repeat (400) @(posedge CLOCK);
		chk(TX_POWER_ON, 1);
		wb(0, 4'h4, 32'h0);
		chk(q[5], 1);
		chk(q[13:8] > 6'h0D && q[13:8] < 6'h13, 1);
		chk({LINE_OUT_A, LINE_OUT_B}, 2'h2);
		MON_LINE <= 1'b0;
		repeat (470) @(posedge CLOCK);
		chk(DRIVER_WATCH, 0);
		repeat (120) @(posedge CLOCK);
		chk(DRIVER_WATCH, 1);
		chk({ALERT_N_OE, ALERT_N_O}, 2'h2);
		MON_LINE <= 1'b1;
		repeat (24) @(posedge CLOCK);
		chk({DRIVER_WATCH, ALERT_N_OE}, 1);
		ser(8'h02, 8'h00);
		chk(ALERT_N_OE, 0);
		rxbits(174, 0);
		chk(SIGNAL_LOSS, 0);
		rxbits(1, 0);
		chk(SIGNAL_LOSS, 1);
		rxbits(1, 1);
		chk({SIGNAL_LOSS, RX_POS_DATA}, 1);
		rxbits(175, 0);
		wb(1, 4'h0, 32'h1);
		chk(SIGNAL_LOSS, 0);
		MODE <= 1'b0;
		rxbits(175, 0);
		REMOTE_LOOP <= 1'b1;
		LOCAL_LOOP <= 1'b1;
		repeat (10) @(posedge CLOCK);
		chk(SIGNAL_LOSS, 0);
		LOCAL_LOOP <= 1'b0;
		tx_run <= 1'b0;
		RX_POS_IN <= 1'b1;
		repeat (80) @(posedge CLOCK);
		chk({TX_POWER_ON, LINE_OUT_A}, 3);
		REMOTE_LOOP <= 1'b0;
		repeat (80) @(posedge CLOCK);
		chk({TX_POWER_ON, LINE_OUT_A, LINE_OUT_B}, 0);
		LOCAL_LOOP <= 1'b1;
		rxbits(2, 1);
		chk({RX_POS_DATA, RX_NEG_DATA}, 0);
		LOCAL_LOOP <= 1'b0;
		tx_run <= 1'b1;
		SEND_ALL_MARKS <= 1'b1;
		repeat (200) @(posedge CLOCK);
		chk(LINE_OUT_A ^ LINE_OUT_B, 1);
		summarize();
	end
endmodule
